//--- src/iwp_pkg.sv
// Package: constants, state codes and carriers of the I2C wiper slave
package iwp_pkg;
  localparam logic [7:0] WIPER_MID    = 8'h80;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] TX_LAST      = 4'h7;
  localparam int         ADDR_SEL_BIT = 1;
  localparam int         ADDR_RW_BIT  = 0;
  localparam int         INSTR_RS_BIT = 6;
  localparam int         INSTR_SD_BIT = 5;
  localparam int         TAPS         = 256;
  localparam logic [1:0] IDX_INSTR    = 2'h0;
  localparam logic [1:0] IDX_DATA     = 2'h1;
  localparam logic [1:0] IDX_EXTRA    = 2'h2;

  typedef enum logic [6:0]
  {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_ACK   = 7'h04,
    ST_RX    = 7'h08,
    ST_TX    = 7'h10,
    ST_TXACK = 7'h20,
    ST_WAIT  = 7'h40
  } iwp_state_t;

  typedef struct packed
  {
    logic       shutdown;
    logic [7:0] wiper;
  } iwp_cfg_t;

  typedef struct packed
  {
    logic scl;
    logic sda;
  } iwp_bus_t;

  localparam iwp_cfg_t CFG_RESET = '{shutdown: 1'b0, wiper: WIPER_MID};
endpackage

//--- src/iwp_slave.sv
// I2C wiper position slave: link-side protocol engine and system-side tap decoder
// Function
// [R1] Reset loads the wiper register with midscale code 128.
// [R2] After reset new wiper positions are accepted over the bus and applied.
// [R3] An 8-bit wiper register decodes to exactly one of 256 tap selects.
// [R4] Code zero selects the bottom contact; each increment moves one tap up.
// [R5] Code 255 selects the top tap; the segment at the top is never used.
// [R6] The master starts a transfer only on an idle bus.
// [R7] SDA changing while SCL is high is taken as START or STOP.
// [R8] The master drives SCL; this slave never drives it.
// [R9] START is SDA falling with SCL high; nothing is done before it.
// [R10] STOP is SDA rising with SCL high; it returns the slave to idle.
// [R11] First byte is an address; its top six bits match a fixed prefix.
// [R12] The seventh address bit must equal the address select pin.
// [R13] A matching address is acknowledged by pulling SDA low on clock nine.
// [R14] A mismatch leaves SDA released and waits for the next START.
// [R15] Last address bit low writes instruction and wiper; high reads the wiper.
// [R16] Writes ack each byte; reads continue after ack, stop after no ack.
// [R17] Instruction bit six high moves the wiper to code 0x80.
// [R18] Instruction bit five high opens top and parks wiper at bottom.
`timescale 1ns/100ps
module iwp_slave
#(
  parameter logic [5:0] DEV_PREFIX = 6'h2A  // Arbitrary device-type prefix
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         link_clk,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic         address_select_pin,
  output logic [255:0]      tap_sel,
  output logic              term_a_open,
  output logic [7:0]        wiper_code
);

  // ==========================================================
  // Link reset: asynchronous assert, release on link clock
  logic [1:0]           lrst_reg;
  logic                 link_rst;

  always_ff @(posedge link_clk or posedge reset)
    if (reset)
      lrst_reg <= 2'h3;
    else
      lrst_reg <= {lrst_reg[0], 1'b0};

  assign link_rst = lrst_reg[1];

  // ==========================================================
  // Pin synchronisers and bus condition detection
  iwp_pkg::iwp_bus_t    bus1_reg;
  iwp_pkg::iwp_bus_t    bus2_reg;
  iwp_pkg::iwp_bus_t    bus3_reg;
  logic                 sel1_reg;
  logic                 sel2_reg;
  logic                 start_det;
  logic                 stop_det;
  logic                 scl_rise;
  logic                 scl_fall;

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      bus1_reg <= 2'h3;
      bus2_reg <= 2'h3;
      bus3_reg <= 2'h3;
      sel1_reg <= 1'b0;
      sel2_reg <= 1'b0;
    end
    else
    begin
      bus1_reg <= '{scl: scl_in, sda: sda_in};
      bus2_reg <= bus1_reg;
      bus3_reg <= bus2_reg;
      sel1_reg <= address_select_pin;
      sel2_reg <= sel1_reg;
    end

  assign start_det = bus2_reg.scl & bus3_reg.scl & bus3_reg.sda & ~bus2_reg.sda;  // [R7] [R9]
  assign stop_det  = bus2_reg.scl & bus3_reg.scl & ~bus3_reg.sda & bus2_reg.sda;  // [R7] [R10]
  assign scl_rise  = bus2_reg.scl & ~bus3_reg.scl;
  assign scl_fall  = ~bus2_reg.scl & bus3_reg.scl;

  // ==========================================================
  // Protocol engine
  iwp_pkg::iwp_state_t  state_reg;
  logic [3:0]           cnt_reg;
  logic [7:0]           shift_reg;
  logic                 rw_reg;
  logic                 addr_phase_reg;
  logic [1:0]           byte_idx_reg;
  logic                 mack_reg;
  logic                 sda_oe_reg;
  logic                 addr_match;
  logic                 byte_done;
  iwp_pkg::iwp_cfg_t    cfg_reg;

  assign addr_match = (shift_reg[7:2] == DEV_PREFIX)                           // [R11]
                    & (shift_reg[iwp_pkg::ADDR_SEL_BIT] == sel2_reg);          // [R12]
  assign byte_done  = (state_reg == iwp_pkg::ST_RX) & scl_fall & (cnt_reg == iwp_pkg::BYTE_BITS);

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      state_reg      <= iwp_pkg::ST_IDLE;
      cnt_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      rw_reg         <= 1'b0;
      addr_phase_reg <= 1'b0;
      byte_idx_reg   <= 2'h0;
      mack_reg       <= 1'b0;
      sda_oe_reg     <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg  <= iwp_pkg::ST_IDLE;  // [R10]
      sda_oe_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg    <= iwp_pkg::ST_ADDR;  // [R9]
      cnt_reg      <= 4'h0;
      byte_idx_reg <= iwp_pkg::IDX_INSTR;
      sda_oe_reg   <= 1'b0;
    end
    else
      case (state_reg)
        iwp_pkg::ST_ADDR, iwp_pkg::ST_RX:
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], bus2_reg.sda};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == iwp_pkg::BYTE_BITS)
          begin
            if (state_reg == iwp_pkg::ST_RX || addr_match)
            begin
              state_reg      <= iwp_pkg::ST_ACK;
              sda_oe_reg     <= 1'b1;  // [R13] [R16]
              addr_phase_reg <= (state_reg == iwp_pkg::ST_ADDR);
              if (state_reg == iwp_pkg::ST_ADDR)
                rw_reg <= shift_reg[iwp_pkg::ADDR_RW_BIT];  // [R15]
              else if (byte_idx_reg != iwp_pkg::IDX_EXTRA)
                byte_idx_reg <= byte_idx_reg + 2'h1;
            end
            else
              state_reg <= iwp_pkg::ST_WAIT;  // [R14]
          end
        iwp_pkg::ST_ACK:
          if (scl_fall)
          begin
            cnt_reg <= 4'h0;
            if (addr_phase_reg && rw_reg)
            begin
              state_reg  <= iwp_pkg::ST_TX;  // [R15]
              shift_reg  <= cfg_reg.wiper;
              sda_oe_reg <= ~cfg_reg.wiper[7];
            end
            else
            begin
              state_reg  <= iwp_pkg::ST_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        iwp_pkg::ST_TX:
          if (scl_fall)
          begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == iwp_pkg::TX_LAST)
            begin
              state_reg  <= iwp_pkg::ST_TXACK;
              sda_oe_reg <= 1'b0;
            end
            else
            begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
            end
          end
        iwp_pkg::ST_TXACK:
          if (scl_rise)
            mack_reg <= ~bus2_reg.sda;
          else if (scl_fall)
          begin
            cnt_reg <= 4'h0;
            if (mack_reg)
            begin
              state_reg  <= iwp_pkg::ST_TX;  // [R16]
              shift_reg  <= cfg_reg.wiper;
              sda_oe_reg <= ~cfg_reg.wiper[7];
            end
            else
              state_reg <= iwp_pkg::ST_WAIT;  // [R16]
          end
        default:
          ;
      endcase

  // Open drain: the line is only ever pulled low, SCL is never driven
  assign sda_out = 1'b0;  // [R8]
  assign sda_oe  = sda_oe_reg;

  // ==========================================================
  // Wiper register and instruction decode (link domain)
  logic                 rs_seen_reg;

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      cfg_reg     <= iwp_pkg::CFG_RESET;  // [R1]
      rs_seen_reg <= 1'b0;
    end
    else if (start_det)
      rs_seen_reg <= 1'b0;
    else if (byte_done && byte_idx_reg == iwp_pkg::IDX_INSTR)
    begin
      cfg_reg.shutdown <= shift_reg[iwp_pkg::INSTR_SD_BIT];  // [R18]
      rs_seen_reg      <= shift_reg[iwp_pkg::INSTR_RS_BIT];
      if (shift_reg[iwp_pkg::INSTR_RS_BIT])
        cfg_reg.wiper <= iwp_pkg::WIPER_MID;  // [R17]
    end
    else if (byte_done && byte_idx_reg == iwp_pkg::IDX_DATA && !rs_seen_reg)
      cfg_reg.wiper <= shift_reg;  // [R2]

  // ==========================================================
  // Crossing to the system clock by request/acknowledge toggles
  iwp_pkg::iwp_cfg_t    xfer_reg;
  logic                 req_reg;
  logic                 ack1_reg;
  logic                 ack2_reg;
  logic                 req1_reg;
  logic                 req2_reg;
  logic                 seen_reg;
  logic                 sys_take;

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      xfer_reg <= iwp_pkg::CFG_RESET;
      req_reg  <= 1'b0;
    end
    else if (req_reg == ack2_reg && xfer_reg != cfg_reg)
    begin
      xfer_reg <= cfg_reg;  // [R2]
      req_reg  <= ~req_reg;
    end

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      ack1_reg <= 1'b0;
      ack2_reg <= 1'b0;
    end
    else
    begin
      ack1_reg <= seen_reg;
      ack2_reg <= ack1_reg;
    end

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      req1_reg <= 1'b0;
      req2_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      req1_reg <= req_reg;
      req2_reg <= req1_reg;
      seen_reg <= req2_reg;
    end

  assign sys_take = req2_reg != seen_reg;

  // ==========================================================
  // Tap decoder (system domain)
  logic [255:0]         tap_next;
  logic [255:0]         tap_reg;
  logic [7:0]           code_reg;
  logic                 open_reg;

  for (genvar i = 0; i < iwp_pkg::TAPS; i++)
  begin : g_tap
    assign tap_next[i] = xfer_reg.shutdown ? (i == 0) : (xfer_reg.wiper == 8'(i));  // [R3] [R4] [R5] [R18]
  end

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      tap_reg  <= 256'h1 << iwp_pkg::WIPER_MID;  // [R1]
      code_reg <= iwp_pkg::WIPER_MID;
      open_reg <= 1'b0;
    end
    else if (sys_take)
    begin
      tap_reg  <= tap_next;  // [R2]
      code_reg <= xfer_reg.wiper;
      open_reg <= xfer_reg.shutdown;
    end

  assign tap_sel     = tap_reg;
  assign wiper_code  = code_reg;
  assign term_a_open = open_reg;

  // ==========================================================
  // Assertions
  property p_reset_mid;
    @(posedge sys_clk) $fell(reset) |-> code_reg == 8'h80 && tap_reg[128];
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("wiper not midscale after reset"); // [R1]

  property p_onehot;
    @(posedge sys_clk) disable iff (reset) $onehot(tap_reg);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap select not one-hot"); // [R3]

  property p_tap_pos;
    @(posedge sys_clk) disable iff (reset) !open_reg |-> tap_reg[code_reg];
  endproperty
  a_tap_pos: assert property (p_tap_pos) else $error("tap does not match code"); // [R4] [R5]

  property p_shutdown;
    @(posedge sys_clk) disable iff (reset) open_reg |-> tap_reg[0];
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown wiper not at bottom"); // [R18]

  property p_apply;
    @(posedge sys_clk) disable iff (reset) sys_take |=> code_reg == $past(xfer_reg.wiper);
  endproperty
  a_apply: assert property (p_apply) else $error("wiper update not applied"); // [R2]

  property p_start;
    @(posedge link_clk) disable iff (link_rst) start_det && !stop_det |=> state_reg == iwp_pkg::ST_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // [R9]

  property p_stop;
    @(posedge link_clk) disable iff (link_rst) stop_det |=> state_reg == iwp_pkg::ST_IDLE && !sda_oe_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle"); // [R10]

  property p_ack;
    @(posedge link_clk) disable iff (link_rst)
      state_reg == iwp_pkg::ST_ADDR && scl_fall && cnt_reg == 4'h8 && addr_match && !start_det && !stop_det
      |=> sda_oe_reg && state_reg == iwp_pkg::ST_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("matching address not acked"); // [R13]

  property p_nomatch;
    @(posedge link_clk) disable iff (link_rst)
      state_reg == iwp_pkg::ST_WAIT && !start_det && !stop_det |=> !sda_oe_reg;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("sda driven while ignoring"); // [R14]

  property p_midscale;
    @(posedge link_clk) disable iff (link_rst)
      byte_done && byte_idx_reg == 2'h0 && shift_reg[6] && !start_det && !stop_det |=> cfg_reg.wiper == 8'h80;
  endproperty
  a_midscale: assert property (p_midscale) else $error("midscale reset ignored"); // [R17]

  property p_idle_quiet;
    @(posedge link_clk) disable iff (link_rst) state_reg == iwp_pkg::ST_IDLE |-> !sda_oe_reg;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven before start"); // [R9]

endmodule

//--- tb/iwp_master.sv
// I2C bus master model that drives the wiper slave
`timescale 1ns/100ps
module iwp_master
#(
  parameter int Q = 5
)
(
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  // ====
  // Bit level, Q system clocks per quarter bit
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bit_out(input logic b);
    tick(Q);
    sda_low <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    scl <= 1'b0;
  endtask
  task automatic bit_in(output logic b);
    tick(Q);
    sda_low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    b = sda_wire;
    tick(Q);
    scl <= 1'b0;
  endtask
  // ====
  // Conditions and bytes
  task automatic start(); // Only called with the bus idle
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0;
    tick(2 * Q);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(nak);
    ack = ~nak;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(~ack);
  endtask
endmodule

//--- tb/iwp_slave_tb_top.sv
// Self-checking bench of the I2C wiper slave
`timescale 1ns/100ps
module iwp_slave_tb_top;
  // ====
  // Clocks, wire and design
  localparam logic [5:0] PREFIX = 6'h2A; // Arbitrary device-type prefix
  typedef struct packed {logic [7:0] ins; logic [7:0] dat; logic [7:0] code; logic sd;} iwp_row_t;
  localparam iwp_row_t ROWS [9] = '{
    '{8'h00, 8'h00, 8'h00, 1'b0}, '{8'h00, 8'h01, 8'h01, 1'b0}, '{8'h9F, 8'hFF, 8'hFF, 1'b0},
    '{8'h00, 8'h80, 8'h80, 1'b0}, '{8'h20, 8'h37, 8'h37, 1'b1}, '{8'h20, 8'h11, 8'h11, 1'b1},
    '{8'h00, 8'h11, 8'h11, 1'b0}, '{8'h60, 8'h12, 8'h80, 1'b1}, '{8'h40, 8'h34, 8'h80, 1'b0}};
  logic         sys_clk;
  logic         reset;
  logic         link_clk;
  logic         scl;
  logic         m_low;
  logic         sda_out;
  logic         sda_oe;
  logic         sel_pin;
  logic [255:0] tap_sel;
  logic         term_a_open;
  logic [7:0]   wiper_code;
  wire logic    sda_wire;
  int           err_count;
  int           samples_checked;
  int           tn;
  // Open-drain line with pull-up
  assign sda_wire = m_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  iwp_slave #(.DEV_PREFIX(PREFIX)) i_iwp_slave (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(sel_pin),
    .tap_sel(tap_sel), .term_a_open(term_a_open), .wiper_code(wiper_code));
  iwp_master i_iwp_master (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(m_low));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // ====
  // Checking and transfers
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fin();
    tn++;
    $display("Test %0d done", tn);
  endtask
  task automatic chk_out(input logic [7:0] code, input logic sd);
    check(tap_sel, sd ? 256'h1 : (256'h1 << code));
    check(term_a_open, sd);
    check(wiper_code, code);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] dat, output logic [2:0] a);
    i_iwp_master.start();
    i_iwp_master.wr_byte(adr, a[2]);
    i_iwp_master.wr_byte(ins, a[1]);
    i_iwp_master.wr_byte(dat, a[0]);
    i_iwp_master.stop();
    repeat (30) @(posedge sys_clk);
  endtask
  task automatic rd1(output logic ack, output logic [7:0] d);
    i_iwp_master.start();
    i_iwp_master.wr_byte({PREFIX, sel_pin, 1'b1}, ack);
    i_iwp_master.rd_byte(1'b0, d);
    i_iwp_master.stop();
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
  // ====
  // Main sequence
  initial
  begin
    logic [2:0] a;
    logic       ack;
    logic [7:0] d;
    reset = 1'b1;
    sel_pin = 1'b0;
    err_count = 0;
    samples_checked = 0;
    tn = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk_out(8'h80, 1'b0);
    foreach (ROWS[i])
    begin
      wr({PREFIX, 2'b00}, ROWS[i].ins, ROWS[i].dat, a);
      check(a, 3'h7);
      chk_out(ROWS[i].code, ROWS[i].sd);
      rd1(ack, d);
      check(ack, 1'b1);
      check(d, ROWS[i].code);
      fin();
    end
    wr({PREFIX ^ 6'h01, 2'b00}, 8'h00, 8'h55, a);
    check(a, 3'h0);
    wr({PREFIX, 2'b10}, 8'h00, 8'h55, a);
    check(a, 3'h0);
    chk_out(8'h80, 1'b0);
    sel_pin <= 1'b1;
    i_iwp_master.wr_byte({PREFIX, 2'b10}, ack);
    check(ack, 1'b0);
    i_iwp_master.wr_byte(8'h55, ack);
    i_iwp_master.stop();
    check(ack, 1'b0);
    chk_out(8'h80, 1'b0);
    fin();
    wr({PREFIX, 2'b10}, 8'h00, 8'h66, a);
    check(a, 3'h7);
    chk_out(8'h66, 1'b0);
    i_iwp_master.start();
    i_iwp_master.wr_byte({PREFIX, 2'b11}, ack);
    i_iwp_master.rd_byte(1'b1, d);
    check(d, 8'h66);
    i_iwp_master.rd_byte(1'b0, d);
    check(d, 8'h66);
    i_iwp_master.stop();
    check(sda_oe, 1'b0);
    fin();
    i_iwp_master.start();
    i_iwp_master.wr_byte({PREFIX, 2'b10}, ack);
    i_iwp_master.wr_byte(8'h00, ack);
    i_iwp_master.wr_byte(8'h21, ack);
    i_iwp_master.wr_byte(8'h99, ack);
    check(ack, 1'b1);
    i_iwp_master.stop();
    repeat (30) @(posedge sys_clk);
    chk_out(8'h21, 1'b0);
    reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk_out(8'h80, 1'b0);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_out(8'h80, 1'b0);
    // Link side must also come back at midscale after a mid-run reset
    repeat (10) @(posedge sys_clk);
    rd1(ack, d);
    check(ack, 1'b1);
    check(d, 8'h80);
    check(sda_out, 1'b0);
    fin();
    conclude();
  end
endmodule
